// file: dcr_pkg.sv
// Constants for the converter configuration register slice
package dcr_pkg;
  // ------------------------------------------------------------
  // Register addresses (serial interfaces, 8-bit)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_DEVICE_MODE   = 8'h25;
  localparam logic [7:0] ADDR_SERIAL_OPTS   = 8'h26;
  localparam logic [7:0] ADDR_PAT_POINTER   = 8'h2B;
  localparam logic [7:0] ADDR_PAT_WORD      = 8'h2C;
  localparam logic [7:0] ADDR_FAST_CODE_0   = 8'h40;
  localparam logic [7:0] ADDR_FAST_CODE_3   = 8'h43;
  localparam logic [7:0] ADDR_ALL_CODE      = 8'h50;
  // ------------------------------------------------------------
  // PMBus page and command addresses
  // ------------------------------------------------------------
  localparam logic [7:0] PM_PAGE_CFG        = 8'hFF;
  localparam logic [7:0] PM_CMD_PAGE        = 8'h00;
  localparam logic [7:0] PM_CMD_DEVICE_MODE = 8'hE9;
  localparam logic [7:0] PM_CMD_PAT_POINTER = 8'hEF;
  localparam logic [7:0] PM_CMD_PAT_WORD    = 8'hF0;
  localparam logic [7:0] PM_CMD_ALL_CODE    = 8'hF1;
  // ------------------------------------------------------------
  // Reset values and write masks
  // ------------------------------------------------------------
  localparam logic [15:0] RST_WORD          = 16'h0000;
  localparam logic [15:0] RST_PAGE          = 16'h0300;
  localparam logic [15:0] MASK_DEVICE_MODE  = 16'hFFE0;
  localparam logic [15:0] MASK_SERIAL_OPTS  = 16'h1105;
  localparam logic [15:0] MASK_HIGH_BYTE    = 16'hFF00;
  localparam logic [15:0] MASK_LOW_BYTE     = 16'h00FF;
  localparam logic [15:0] MASK_ALL_CODE     = 16'hFFF0;
  // ------------------------------------------------------------
  // Field positions and array sizes
  // ------------------------------------------------------------
  localparam int BIT_LOW_POWER   = 13;
  localparam int BIT_PROT_HI     = 9;
  localparam int BIT_PROT_LO     = 8;
  localparam int BIT_TIMEOUT     = 12;
  localparam int BIT_PMBUS       = 8;
  localparam int BIT_FAST_SDO    = 2;
  localparam int BIT_SDO         = 0;
  localparam int CHANNELS        = 4;
  localparam int MEM_DEPTH       = 256;
  // ------------------------------------------------------------
  // Protection responses
  // ------------------------------------------------------------
  localparam logic [1:0] PROT_HIZ        = 2'h0;
  localparam logic [1:0] PROT_NVM        = 2'h1;
  localparam logic [1:0] PROT_MARGIN_LOW = 2'h2;
  localparam logic [1:0] PROT_MARGIN_HI  = 2'h3;
  // ------------------------------------------------------------
  // Protection sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    DCR_IDLE  = 4'b0001,
    DCR_JUMP  = 4'b0010,
    DCR_SLEW  = 4'b0100,
    DCR_HIZ   = 4'b1000
  } dcr_prot_e;
  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_JUMP = 2'h1;
  localparam logic [1:0] ACT_SLEW = 2'h2;
  localparam logic [1:0] ACT_HIZ  = 2'h3;
endpackage

// file: dcr_regs.sv
// Register slice: device mode, serial options, pattern memory, channel codes
//
// Contract
// - Response 00: jump straight to Hi-Z.
// - Response 01: jump NVM code, then Hi-Z.
// - Response 10: slew margin-low, then Hi-Z.
// - Response 11: slew margin-high, then Hi-Z.
// - Bit 8 enables PMBus, reset zero.
// - Bit 2 selects fast readback timing.
// - Bit 0 routes readback onto SDO.
// - Pointer write sets next memory location.
// - Pointer advances after each data write.
// - Data register accesses pointed memory word.
// - Channel fast codes at 40h-43h, bits 15-8.
// - Broadcast write updates enabled channels.
// - Broadcast code is MSB left-aligned.
// - Channel takes broadcast only when enabled.
// - PMBus: device mode at FFh/E9h.
// - PMBus: pointer EFh, data F0h, page FFh.
// - PMBus: broadcast at F1h page FFh.
// - Fast codes unreachable over PMBus.
// - Page register at 00h, any page, 0300h.
// - Page register bits 15-8 hold page.
`timescale 1ns/10ps
module dcr_regs (
  // Clock and control
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // Serial register port (I2C or SPI)
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  // PMBus command port
  input  wire logic        pm_wr,
  input  wire logic        pm_rd,
  input  wire logic [7:0]  pm_cmd,
  input  wire logic [15:0] pm_wdata,
  // Read answer
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  // Channel side
  input  wire logic [3:0]  channel_broadcast_enable,
  input  wire logic        protect_pin,
  output logic [3:0]       chan_load,
  output logic [15:0]      chan_code_0,
  output logic [15:0]      chan_code_1,
  output logic [15:0]      chan_code_2,
  output logic [15:0]      chan_code_3,
  output logic [1:0]       prot_action,
  output logic [1:0]       prot_target,
  input  wire logic        slew_done,
  // Interface options
  output logic             low_power_mode_select,
  output logic             timeout_enable,
  output logic             pmbus_enable,
  output logic             fast_readback_enable,
  output logic             readback_output_enable
);
  logic [15:0] device_mode;
  logic [15:0] serial_opts;
  logic [7:0]  pat_pointer;
  logic [15:0] all_code;
  logic [15:0] pm_page;
  logic [15:0] fast_code [dcr_pkg::CHANNELS];
  logic [15:0] pat_mem [dcr_pkg::MEM_DEPTH];
  logic [2:0]  prot_sync;
  logic        prot_seen;
  dcr_pkg::dcr_prot_e state;
  dcr_pkg::dcr_prot_e next_state;
  // ------------------------------------------------------------
  // Access decoding
  // ------------------------------------------------------------
  function automatic logic is_fast(input logic [7:0] a);
    return (a >= dcr_pkg::ADDR_FAST_CODE_0) && (a <= dcr_pkg::ADDR_FAST_CODE_3);
  endfunction
  wire on_cfg_page = pm_page[15:8] == dcr_pkg::PM_PAGE_CFG;
  wire pm_ok_wr    = pm_wr && pmbus_enable;
  wire pm_ok_rd    = pm_rd && pmbus_enable;
  wire pm_cfg_wr   = pm_ok_wr && on_cfg_page;
  wire pm_cfg_rd   = pm_ok_rd && on_cfg_page;
  wire wr_mode  = (reg_wr && reg_addr == dcr_pkg::ADDR_DEVICE_MODE)
               || (pm_cfg_wr && pm_cmd == dcr_pkg::PM_CMD_DEVICE_MODE);
  wire wr_opts  = reg_wr && reg_addr == dcr_pkg::ADDR_SERIAL_OPTS;
  wire wr_ptr   = (reg_wr && reg_addr == dcr_pkg::ADDR_PAT_POINTER)
               || (pm_cfg_wr && pm_cmd == dcr_pkg::PM_CMD_PAT_POINTER);
  wire wr_word  = (reg_wr && reg_addr == dcr_pkg::ADDR_PAT_WORD)
               || (pm_cfg_wr && pm_cmd == dcr_pkg::PM_CMD_PAT_WORD);
  wire wr_all   = (reg_wr && reg_addr == dcr_pkg::ADDR_ALL_CODE)
               || (pm_cfg_wr && pm_cmd == dcr_pkg::PM_CMD_ALL_CODE);
  wire wr_page  = pm_ok_wr && pm_cmd == dcr_pkg::PM_CMD_PAGE;
  wire wr_fast  = reg_wr && is_fast(reg_addr);
  wire [1:0] fast_idx = reg_addr[1:0];
  wire [1:0] prot_cfg = device_mode[dcr_pkg::BIT_PROT_HI:dcr_pkg::BIT_PROT_LO];
  wire [15:0] wdata  = reg_wr ? reg_wdata : pm_wdata;
  wire [15:0] all_val = wdata & dcr_pkg::MASK_ALL_CODE;
  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  logic [15:0] next_rd;
  always_comb begin
    next_rd = dcr_pkg::RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        dcr_pkg::ADDR_DEVICE_MODE: next_rd = device_mode;
        dcr_pkg::ADDR_SERIAL_OPTS: next_rd = serial_opts;
        dcr_pkg::ADDR_PAT_POINTER: next_rd = {8'h00, pat_pointer};
        dcr_pkg::ADDR_PAT_WORD:    next_rd = pat_mem[pat_pointer];
        dcr_pkg::ADDR_ALL_CODE:    next_rd = all_code;
        default: begin
          if (is_fast(reg_addr)) begin
            next_rd = fast_code[reg_addr[1:0]];
          end
        end
      endcase
    end else if (pm_ok_rd) begin
      if (pm_cmd == dcr_pkg::PM_CMD_PAGE) begin
        next_rd = pm_page;
      end else if (on_cfg_page) begin
        case (pm_cmd)
          dcr_pkg::PM_CMD_DEVICE_MODE: next_rd = device_mode;
          dcr_pkg::PM_CMD_PAT_POINTER: next_rd = {8'h00, pat_pointer};
          dcr_pkg::PM_CMD_PAT_WORD:    next_rd = pat_mem[pat_pointer];
          dcr_pkg::PM_CMD_ALL_CODE:    next_rd = all_code;
          default:                     next_rd = dcr_pkg::RST_WORD;
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      device_mode <= dcr_pkg::RST_WORD;
      serial_opts <= dcr_pkg::RST_WORD;
      pat_pointer <= 8'h00;
      all_code    <= dcr_pkg::RST_WORD;
      pm_page     <= dcr_pkg::RST_PAGE;
      rd_data     <= dcr_pkg::RST_WORD;
      rd_valid    <= 1'b0;
      for (int i = 0; i < dcr_pkg::CHANNELS; i++) begin
        fast_code[i] <= dcr_pkg::RST_WORD;
      end
    end else if (clk_en) begin
      rd_data  <= next_rd;
      rd_valid <= reg_rd || pm_ok_rd;
      if (wr_mode) device_mode <= wdata & dcr_pkg::MASK_DEVICE_MODE;
      if (wr_opts) serial_opts <= wdata & dcr_pkg::MASK_SERIAL_OPTS;
      if (wr_page) pm_page <= wdata & dcr_pkg::MASK_HIGH_BYTE;
      if (wr_all) all_code <= all_val;
      if (wr_fast) fast_code[fast_idx] <= wdata & dcr_pkg::MASK_HIGH_BYTE;
      if (wr_ptr) begin
        pat_pointer <= wdata[7:0];
      end else if (wr_word) begin
        pat_pointer <= pat_pointer + 8'h01;
      end
    end
  end
  // Pattern memory has no reset
  always_ff @(posedge core_clk) begin
    if (clk_en && wr_word) begin
      pat_mem[pat_pointer] <= wdata;
    end
  end
  // ------------------------------------------------------------
  // Channel code outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      chan_load   <= 4'h0;
      chan_code_0 <= dcr_pkg::RST_WORD;
      chan_code_1 <= dcr_pkg::RST_WORD;
      chan_code_2 <= dcr_pkg::RST_WORD;
      chan_code_3 <= dcr_pkg::RST_WORD;
    end else if (clk_en) begin
      chan_load <= wr_all ? channel_broadcast_enable : 4'h0;
      if (wr_all && channel_broadcast_enable[0]) chan_code_0 <= all_val;
      if (wr_all && channel_broadcast_enable[1]) chan_code_1 <= all_val;
      if (wr_all && channel_broadcast_enable[2]) chan_code_2 <= all_val;
      if (wr_all && channel_broadcast_enable[3]) chan_code_3 <= all_val;
    end
  end
  // ------------------------------------------------------------
  // Interface option outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_power_mode_select  <= 1'b0;
      timeout_enable         <= 1'b0;
      pmbus_enable           <= 1'b0;
      fast_readback_enable   <= 1'b0;
      readback_output_enable <= 1'b0;
    end else if (clk_en) begin
      low_power_mode_select  <= device_mode[dcr_pkg::BIT_LOW_POWER];
      timeout_enable         <= serial_opts[dcr_pkg::BIT_TIMEOUT];
      pmbus_enable           <= serial_opts[dcr_pkg::BIT_PMBUS];
      fast_readback_enable   <= serial_opts[dcr_pkg::BIT_FAST_SDO];
      readback_output_enable <= serial_opts[dcr_pkg::BIT_SDO];
    end
  end
  // ------------------------------------------------------------
  // Protect pin synchroniser and response sequencer
  // ------------------------------------------------------------
  wire prot_rise = prot_sync[1] && prot_sync[2] && !prot_seen;
  always_comb begin
    next_state = state;
    case (state)
      dcr_pkg::DCR_IDLE: begin
        if (prot_rise) begin
          case (prot_cfg)
            dcr_pkg::PROT_HIZ: next_state = dcr_pkg::DCR_HIZ;
            dcr_pkg::PROT_NVM: next_state = dcr_pkg::DCR_JUMP;
            default:           next_state = dcr_pkg::DCR_SLEW;
          endcase
        end
      end
      dcr_pkg::DCR_JUMP: next_state = dcr_pkg::DCR_HIZ;
      dcr_pkg::DCR_SLEW: if (slew_done) next_state = dcr_pkg::DCR_HIZ;
      dcr_pkg::DCR_HIZ:  if (!prot_sync[2]) next_state = dcr_pkg::DCR_IDLE;
      default:           next_state = dcr_pkg::DCR_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prot_sync   <= 3'h0;
      prot_seen   <= 1'b0;
      state       <= dcr_pkg::DCR_IDLE;
      prot_action <= dcr_pkg::ACT_NONE;
      prot_target <= dcr_pkg::PROT_HIZ;
    end else if (clk_en) begin
      prot_sync <= {prot_sync[1:0], protect_pin};
      if (prot_sync[1] == prot_sync[2]) prot_seen <= prot_sync[2];
      state <= next_state;
      if (prot_rise) prot_target <= prot_cfg;
      case (next_state)
        dcr_pkg::DCR_JUMP: prot_action <= dcr_pkg::ACT_JUMP;
        dcr_pkg::DCR_SLEW: prot_action <= dcr_pkg::ACT_SLEW;
        dcr_pkg::DCR_HIZ:  prot_action <= dcr_pkg::ACT_HIZ;
        default:           prot_action <= dcr_pkg::ACT_NONE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_opts_mask;
    @(posedge core_clk) disable iff (srst)
      (clk_en && wr_opts) |=> ((serial_opts & ~dcr_pkg::MASK_SERIAL_OPTS) == 16'h0000);
  endproperty
  a_opts_mask: assert property (p_opts_mask) else $error("Don't-care bits stored");
  property p_pmbus_out;
    @(posedge core_clk) disable iff (srst)
      clk_en |=> (pmbus_enable == $past(serial_opts[dcr_pkg::BIT_PMBUS]));
  endproperty
  a_pmbus_out: assert property (p_pmbus_out) else $error("PMBus enable mismatch");
  property p_ptr_inc;
    @(posedge core_clk) disable iff (srst)
      (clk_en && wr_word && !wr_ptr) |=> (pat_pointer == $past(pat_pointer) + 8'h01);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("Pointer did not advance");
  property p_ptr_set;
    @(posedge core_clk) disable iff (srst)
      (clk_en && wr_ptr) |=> (pat_pointer == $past(wdata[7:0]));
  endproperty
  a_ptr_set: assert property (p_ptr_set) else $error("Pointer not loaded");
  property p_bcast_gate;
    @(posedge core_clk) disable iff (srst)
      (clk_en && wr_all && !channel_broadcast_enable[0]) |=> $stable(chan_code_0);
  endproperty
  a_bcast_gate: assert property (p_bcast_gate) else $error("Disabled channel loaded");
  property p_bcast_load;
    @(posedge core_clk) disable iff (srst)
      (clk_en && wr_all && channel_broadcast_enable[1]) |=> (chan_code_1[3:0] == 4'h0
        && chan_code_1 == $past(wdata & dcr_pkg::MASK_ALL_CODE));
  endproperty
  a_bcast_load: assert property (p_bcast_load) else $error("Broadcast code wrong");
  property p_hiz_direct;
    @(posedge core_clk) disable iff (srst)
      (clk_en && state == dcr_pkg::DCR_IDLE && prot_rise && prot_cfg == dcr_pkg::PROT_HIZ)
        |=> (prot_action == dcr_pkg::ACT_HIZ);
  endproperty
  a_hiz_direct: assert property (p_hiz_direct) else $error("No direct Hi-Z");
  property p_nvm_then_hiz;
    @(posedge core_clk) disable iff (srst)
      (clk_en && state == dcr_pkg::DCR_IDLE && prot_rise && prot_cfg == dcr_pkg::PROT_NVM)
        |=> (prot_action == dcr_pkg::ACT_JUMP)
        ##1 (!$past(clk_en) || prot_action == dcr_pkg::ACT_HIZ);
  endproperty
  a_nvm_then_hiz: assert property (p_nvm_then_hiz) else $error("NVM jump order");
  property p_slew_first;
    @(posedge core_clk) disable iff (srst)
      (clk_en && state == dcr_pkg::DCR_IDLE && prot_rise
        && (prot_cfg == dcr_pkg::PROT_MARGIN_LOW || prot_cfg == dcr_pkg::PROT_MARGIN_HI))
        |=> (prot_action == dcr_pkg::ACT_SLEW);
  endproperty
  a_slew_first: assert property (p_slew_first) else $error("No slew before Hi-Z");
  property p_slew_hold;
    @(posedge core_clk) disable iff (srst)
      (state == dcr_pkg::DCR_SLEW && !slew_done) |=> (state == dcr_pkg::DCR_SLEW);
  endproperty
  a_slew_hold: assert property (p_slew_hold) else $error("Slew left early");
  property p_page_reset;
    @(posedge core_clk) srst |=> (pm_page == dcr_pkg::RST_PAGE);
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("Page reset value");
endmodule

// file: dcr_host.sv
// Host controller model driving the serial and PMBus register ports
`timescale 1ns/10ps
module dcr_host (
  // Clock
  input  wire logic        core_clk,
  // Serial register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  // PMBus command port
  output logic             pm_wr,
  output logic             pm_rd,
  output logic [7:0]       pm_cmd,
  output logic [15:0]      pm_wdata,
  // Read answer
  input  wire logic [15:0] rd_data
);
  initial begin
    {reg_wr, reg_rd, pm_wr, pm_rd} = 4'h0;
    {reg_addr, pm_cmd} = 16'h0000;
    {reg_wdata, pm_wdata} = 32'h0000_0000;
  end

  // One request held over its taking edge; idle lines show the inverse
  task automatic acc(input logic pm, input logic wr, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk);
    reg_wr    <= wr & ~pm;
    reg_rd    <= ~wr & ~pm;
    pm_wr     <= wr & pm;
    pm_rd     <= ~wr & pm;
    reg_addr  <= a;
    pm_cmd    <= a;
    reg_wdata <= d;
    pm_wdata  <= d;
    @(posedge core_clk);
    {reg_wr, reg_rd, pm_wr, pm_rd} <= 4'h0;
    reg_addr  <= ~a;
    pm_cmd    <= ~a;
    reg_wdata <= ~d;
    pm_wdata  <= ~d;
    #1;
    q = rd_data;
  endtask
endmodule

// file: tb_dac_config_register_slice.sv
// Self-checking testbench for the register slice
`timescale 1ns/10ps
module tb_dac_config_register_slice;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_en = 1'b1;
  logic        reg_wr, reg_rd, pm_wr, pm_rd, rd_valid;
  logic [7:0]  reg_addr, pm_cmd;
  logic [15:0] reg_wdata, pm_wdata, rd_data, q;
  logic [3:0]  bc_en = 4'h0;
  logic        protect_pin = 1'b0;
  logic        slew_done = 1'b0;
  logic [3:0]  chan_load, load_seen;
  logic [15:0] code0, code1, code2, code3;
  logic [1:0]  prot_action, prot_target;
  logic        lp, to_en, pm_en, fast_en, rb_en;
  int          err_total = 0;
  int          compares = 0;

  always #2.5 core_clk = ~core_clk;

  dcr_host u_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pm_wr(pm_wr), .pm_rd(pm_rd),
    .pm_cmd(pm_cmd), .pm_wdata(pm_wdata), .rd_data(rd_data));

  dcr_regs u_dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .pm_wr(pm_wr), .pm_rd(pm_rd), .pm_cmd(pm_cmd), .pm_wdata(pm_wdata),
    .rd_data(rd_data), .rd_valid(rd_valid), .channel_broadcast_enable(bc_en),
    .protect_pin(protect_pin), .chan_load(chan_load), .chan_code_0(code0),
    .chan_code_1(code1), .chan_code_2(code2), .chan_code_3(code3),
    .prot_action(prot_action), .prot_target(prot_target), .slew_done(slew_done),
    .low_power_mode_select(lp), .timeout_enable(to_en), .pmbus_enable(pm_en),
    .fast_readback_enable(fast_en), .readback_output_enable(rb_en));

  // Collect every channel load pulse
  always @(posedge core_clk) begin
    if (srst) load_seen <= 4'h0;
    else load_seen <= load_seen | chan_load;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic pm, input logic [7:0] a, input logic [15:0] d);
    u_host.acc(pm, 1'b1, a, d, q);
  endtask

  task automatic rd(input logic pm, input logic [7:0] a, input logic [15:0] e);
    u_host.acc(pm, 1'b0, a, 16'h0000, q);
    chk(q, e);
    if (!pm) chk({15'h0000, rd_valid}, 16'h0001);
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_act(input logic [1:0] e);
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      #1;
      if (prot_action === e) break;
    end
    chk({14'h0000, prot_action}, {14'h0000, e});
  endtask

  task automatic stop_test();
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    stop_test();
  end

  initial begin
    logic [15:0] bits [4];
    bits = '{16'h1000, 16'h0100, 16'h0004, 16'h0001};
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    // ------------------------------------------------------------
    // Reset values and unmapped place
    // ------------------------------------------------------------
    rd(0, dcr_pkg::ADDR_DEVICE_MODE, 16'h0000);
    rd(0, dcr_pkg::ADDR_SERIAL_OPTS, 16'h0000);
    rd(0, dcr_pkg::ADDR_PAT_POINTER, 16'h0000);
    rd(0, dcr_pkg::ADDR_ALL_CODE, 16'h0000);
    rd(0, 8'h30, 16'h0000);
    // ------------------------------------------------------------
    // Option bits one at a time, then don't-care bits
    // ------------------------------------------------------------
    for (int b = 0; b < 4; b++) begin
      wr(0, dcr_pkg::ADDR_SERIAL_OPTS, bits[b]);
      settle();
      chk({3'h0, to_en, 3'h0, pm_en, 5'h00, fast_en, 1'b0, rb_en}, bits[b]);
    end
    wr(0, dcr_pkg::ADDR_SERIAL_OPTS, 16'hEEFA);
    rd(0, dcr_pkg::ADDR_SERIAL_OPTS, 16'h0000);
    wr(0, dcr_pkg::ADDR_DEVICE_MODE, 16'hFFFF);
    rd(0, dcr_pkg::ADDR_DEVICE_MODE, 16'hFFE0);
    settle();
    chk({15'h0000, lp}, 16'h0001);
    // ------------------------------------------------------------
    // Pattern memory with pointer wrap and frozen clock enable
    // ------------------------------------------------------------
    wr(0, dcr_pkg::ADDR_PAT_POINTER, 16'hFFFE);
    wr(0, dcr_pkg::ADDR_PAT_WORD, 16'hA1A1);
    wr(0, dcr_pkg::ADDR_PAT_WORD, 16'hB2B2);
    wr(0, dcr_pkg::ADDR_PAT_WORD, 16'hC3C3);
    rd(0, dcr_pkg::ADDR_PAT_POINTER, 16'h0001);
    @(posedge core_clk) clk_en <= 1'b0;
    wr(0, dcr_pkg::ADDR_PAT_WORD, 16'hDEAD);
    @(posedge core_clk) clk_en <= 1'b1;
    rd(0, dcr_pkg::ADDR_PAT_POINTER, 16'h0001);
    wr(0, dcr_pkg::ADDR_PAT_POINTER, 16'h00FE);
    rd(0, dcr_pkg::ADDR_PAT_WORD, 16'hA1A1);
    rd(0, dcr_pkg::ADDR_PAT_WORD, 16'hA1A1);
    wr(0, dcr_pkg::ADDR_PAT_POINTER, 16'h0000);
    rd(0, dcr_pkg::ADDR_PAT_WORD, 16'hC3C3);
    // ------------------------------------------------------------
    // Fast codes and serial broadcast
    // ------------------------------------------------------------
    for (int c = 0; c < 4; c++) begin
      wr(0, dcr_pkg::ADDR_FAST_CODE_0 + 8'(c), {8'(8'h11 * (c + 1)), 8'h5A});
    end
    for (int c = 0; c < 4; c++) begin
      rd(0, dcr_pkg::ADDR_FAST_CODE_0 + 8'(c), {8'(8'h11 * (c + 1)), 8'h00});
    end
    @(posedge core_clk) bc_en <= 4'h5;
    wr(0, dcr_pkg::ADDR_ALL_CODE, 16'hABCD);
    settle();
    chk({12'h000, load_seen}, 16'h0005);
    chk(code0, 16'hABC0);
    chk(code2, 16'hABC0);
    rd(0, dcr_pkg::ADDR_ALL_CODE, 16'hABC0);
    // ------------------------------------------------------------
    // PMBus access, pages and refusals
    // ------------------------------------------------------------
    wr(0, dcr_pkg::ADDR_SERIAL_OPTS, 16'h0000);
    rd(1, dcr_pkg::PM_CMD_PAGE, 16'h0000);
    wr(0, dcr_pkg::ADDR_SERIAL_OPTS, 16'h0100);
    settle();
    rd(1, dcr_pkg::PM_CMD_PAGE, 16'h0300);
    rd(1, dcr_pkg::PM_CMD_DEVICE_MODE, 16'h0000);
    wr(1, dcr_pkg::PM_CMD_PAGE, 16'hFF34);
    rd(1, dcr_pkg::PM_CMD_PAGE, 16'hFF00);
    wr(1, dcr_pkg::PM_CMD_DEVICE_MODE, 16'h2000);
    rd(0, dcr_pkg::ADDR_DEVICE_MODE, 16'h2000);
    wr(1, dcr_pkg::PM_CMD_PAT_POINTER, 16'h0010);
    wr(1, dcr_pkg::PM_CMD_PAT_WORD, 16'h7E57);
    rd(0, dcr_pkg::ADDR_PAT_POINTER, 16'h0011);
    wr(0, dcr_pkg::ADDR_PAT_POINTER, 16'h0010);
    rd(1, dcr_pkg::PM_CMD_PAT_WORD, 16'h7E57);
    @(posedge core_clk) bc_en <= 4'hA;
    wr(1, dcr_pkg::PM_CMD_ALL_CODE, 16'h1237);
    settle();
    chk({12'h000, load_seen}, 16'h000F);
    chk(code3, 16'h1230);
    chk(code1, 16'h1230);
    chk(code0, 16'hABC0);
    rd(1, dcr_pkg::ADDR_FAST_CODE_0, 16'h0000);
    // ------------------------------------------------------------
    // Protection responses
    // ------------------------------------------------------------
    for (int c = 0; c < 4; c++) begin
      wr(0, dcr_pkg::ADDR_DEVICE_MODE, {6'h00, 2'(c), 8'h00});
      settle();
      @(posedge core_clk) protect_pin <= 1'b1;
      wait_act(c == 0 ? dcr_pkg::ACT_HIZ : c == 1 ? dcr_pkg::ACT_JUMP : dcr_pkg::ACT_SLEW);
      chk({14'h0000, prot_target}, 16'(c));
      @(posedge core_clk) slew_done <= 1'b1;
      wait_act(dcr_pkg::ACT_HIZ);
      @(posedge core_clk) protect_pin <= 1'b0;
      slew_done <= 1'b0;
      wait_act(dcr_pkg::ACT_NONE);
    end
    stop_test();
  end
endmodule
